// ---- core/ddr_burst_pkg.sv ----
// Shared constants, carriers and burst decode for the read/write burst sequencer.
// Assumes the command/data link is clocked by the controller clock and configuration by the core clock.
package ddr_burst_pkg;

    localparam int CLK_PERIOD_NS = 8;
    localparam int DQ_WIDTH = 16;
    localparam int PAIR_W = 2 * DQ_WIDTH;
    localparam int NUM_BANKS = 8;
    localparam int BANK_W = 3;
    localparam int COL_W = 4;
    localparam int DELAY_W = 5;

    // Burst field of mode word zero
    localparam logic [1:0] BURST_FIXED_FULL = 2'h0;
    localparam logic [1:0] BURST_PER_COMMAND = 2'h1;
    localparam logic [1:0] BURST_FIXED_CHOP = 2'h2;

    // Clocks of data per burst, two beats per clock
    localparam int CLOCKS_FULL = 4;
    localparam int CLOCKS_CHOP = 2;
    localparam logic [1:0] BEAT_LAST_FULL = 2'(CLOCKS_FULL - 1);
    localparam logic [1:0] BEAT_LAST_CHOP = 2'(CLOCKS_CHOP - 1);

    // Reset values of the configuration
    localparam logic [1:0] BURST_FIELD_RESET = 2'h0;
    localparam logic [DELAY_W-1:0] ADDITIVE_DELAY_RESET = 5'h00;
    localparam logic [DELAY_W-1:0] COLUMN_READ_DELAY_RESET = 5'h0b;
    localparam logic [DELAY_W-1:0] COLUMN_WRITE_DELAY_RESET = 5'h09;

    typedef struct packed {
        logic [1:0] burst_field;
        logic [DELAY_W-1:0] additive_delay;
        logic [DELAY_W-1:0] column_read_delay;
        logic [DELAY_W-1:0] column_write_delay;
    } cfg_t;

    localparam cfg_t CFG_RESET = '{
        burst_field: BURST_FIELD_RESET,
        additive_delay: ADDITIVE_DELAY_RESET,
        column_read_delay: COLUMN_READ_DELAY_RESET,
        column_write_delay: COLUMN_WRITE_DELAY_RESET
    };

    typedef struct packed {
        logic rd;
        logic wr;
        logic act;
        logic pre;
        logic autoclose_address_bit;
        logic burst_chop_address_bit;
        logic [BANK_W-1:0] bank;
        logic [COL_W-1:0] col;
    } cmd_t;

    typedef struct packed {
        logic valid;
        logic rd;
        logic chop;
        logic autoclose;
        logic [BANK_W-1:0] bank;
        logic [COL_W-1:0] col;
    } slot_t;

    // Chop decision from the burst field and the command's chop bit
    function automatic logic burst_is_chop(input logic [1:0] field, input logic chop_bit);
        case (field)
            BURST_FIXED_CHOP: burst_is_chop = 1'b1;
            BURST_PER_COMMAND: burst_is_chop = ~chop_bit;
            default: burst_is_chop = 1'b0;
        endcase
    endfunction : burst_is_chop

endpackage : ddr_burst_pkg

// ---- core/cfg_crossing.sv ----
// Handshake crossing that carries a configuration word from one clock to another.
// Assumes the source word is quasi-static; each domain supplies its own synchronous reset.
module cfg_crossing #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic src_clk,
    input wire logic src_reset,
    input wire logic [WIDTH-1:0] src_data,
    input wire logic dst_clk,
    input wire logic dst_reset,
    output logic [WIDTH-1:0] dst_data
);

    logic [WIDTH-1:0] hold;
    logic req;
    logic ack;
    logic [1:0] ack_sync;
    logic [1:0] req_sync;

    if (WIDTH < 1) begin : g_width_check
        $error("cfg_crossing needs a positive width");
    end

    // Source: latch a new word once the previous one is acknowledged
    always_ff @(posedge src_clk) begin
        if (src_reset) begin
            hold <= RESET_VALUE;
            req <= 1'b0;
        end else if (ack_sync[1] == req) begin
            hold <= src_data;
            req <= ~req;
        end
    end

    always_ff @(posedge src_clk) begin
        if (src_reset) begin
            ack_sync <= 2'h0;
        end else begin
            ack_sync <= {ack_sync[0], ack};
        end
    end

    // Destination: take the held word when the request toggles
    always_ff @(posedge dst_clk) begin
        if (dst_reset) begin
            req_sync <= 2'h0;
            ack <= 1'b0;
            dst_data <= RESET_VALUE;
        end else begin
            req_sync <= {req_sync[0], req};
            if (req_sync[1] != ack) begin
                dst_data <= hold;
                ack <= req_sync[1];
            end
        end
    end

endmodule : cfg_crossing

// ---- core/ddr_burst_device.sv ----
// Read and write burst sequencing of the memory device: latency, burst length, autoclose, bank state.
// Assumes commands and data are synchronous to link_clk and configuration is written on clk.
//
// Overview of operation
// - Reads run as fixed eight-beat, fixed four-beat chop, or per-command choice.
// - Per-command mode: chop bit low gives four-beat chop, high gives eight beats.
// - Per-command burst choice works the same with or without autoclose.
// - Read with autoclose bit low leaves the bank open after the burst.
// - Read with autoclose bit high closes the bank automatically after the burst.
// - Chop applies with burst field 1:0, or 0:1 with the chop bit low.
// - Eight beats apply with burst field 00, or 01 with the chop bit high.
// - Drive stops at read latency plus four clocks, or plus two for a chop.
module ddr_burst_device
    import ddr_burst_pkg::*;
#(
    parameter int LAT_DEPTH = 64
) (
    input wire logic clk,
    input wire logic reset,
    input wire cfg_t cfg,
    output logic [NUM_BANKS-1:0] bank_open_status,
    input wire logic link_clk,
    input wire cmd_t cmd,
    input wire logic [PAIR_W-1:0] dq_in,
    output logic [PAIR_W-1:0] dq_out,
    output logic dq_oe_n,
    output logic dqs_out,
    output logic dqs_oe_n
);

    localparam int LAT_W = $clog2(LAT_DEPTH);
    localparam int MEM_DEPTH = 2 ** (COL_W + 2);

    if (LAT_DEPTH < 2 * (2 ** DELAY_W) - 1) begin : g_depth_check
        $error("LAT_DEPTH too small for the largest latency sum");
    end

    logic [1:0] link_reset_sync;
    logic link_reset;
    cfg_t link_cfg;
    logic [LAT_W-1:0] read_latency_sum;
    logic [LAT_W-1:0] write_latency_sum;
    logic [LAT_W-1:0] ins_pos;
    slot_t next_slot;
    slot_t line [LAT_DEPTH];
    logic fire;
    logic rd_fire;
    logic busy;
    logic is_rd;
    logic chop;
    logic autoclose;
    logic [1:0] beat;
    logic [BANK_W-1:0] bank;
    logic [COL_W-1:0] col;
    logic last_beat;
    logic [PAIR_W-1:0] mem [MEM_DEPTH];
    logic [NUM_BANKS-1:0] bank_open;
    logic [NUM_BANKS-1:0] bank_sync;

    // Reset brought into the link domain
    always_ff @(posedge link_clk) begin
        link_reset_sync <= {link_reset_sync[0], reset};
    end
    assign link_reset = link_reset_sync[1];

    cfg_crossing #(
        .WIDTH($bits(cfg_t)),
        .RESET_VALUE(CFG_RESET)
    ) u_cfg_crossing (
        .src_clk(clk),
        .src_reset(reset),
        .src_data(cfg),
        .dst_clk(link_clk),
        .dst_reset(link_reset),
        .dst_data(link_cfg)
    );

    // Latency sums
    always_ff @(posedge link_clk) begin
        if (link_reset) begin
            read_latency_sum <= LAT_W'(ADDITIVE_DELAY_RESET) + LAT_W'(COLUMN_READ_DELAY_RESET);
            write_latency_sum <= LAT_W'(ADDITIVE_DELAY_RESET) + LAT_W'(COLUMN_WRITE_DELAY_RESET);
        end else begin
            read_latency_sum <= LAT_W'(link_cfg.additive_delay) + LAT_W'(link_cfg.column_read_delay);
            write_latency_sum <= LAT_W'(link_cfg.additive_delay) + LAT_W'(link_cfg.column_write_delay);
        end
    end

    // Command decode into a delay-line slot
    always_comb begin
        next_slot.valid = cmd.rd | cmd.wr;
        next_slot.rd = cmd.rd;
        next_slot.chop = burst_is_chop(link_cfg.burst_field, cmd.burst_chop_address_bit);
        next_slot.autoclose = cmd.autoclose_address_bit;
        next_slot.bank = cmd.bank;
        next_slot.col = cmd.col;
    end

    always_comb begin
        ins_pos = cmd.rd ? read_latency_sum : write_latency_sum;
        if (ins_pos != '0) begin
            ins_pos = ins_pos - 1'b1;
        end
    end

    // Delay line: a slot placed at latency-1 reaches the head latency-1 clocks later
    for (genvar i = 0; i < LAT_DEPTH; i++) begin : g_line
        localparam int SRC = (i == LAT_DEPTH - 1) ? i : i + 1;
        always_ff @(posedge link_clk) begin
            if (link_reset) begin
                line[i] <= '0;
            end else if (next_slot.valid && ins_pos == LAT_W'(i)) begin
                line[i] <= next_slot;
            end else if (i == LAT_DEPTH - 1) begin
                line[i] <= '0;
            end else begin
                line[i] <= line[SRC];
            end
        end
    end

    assign fire = line[0].valid;
    assign rd_fire = fire & line[0].rd;
    assign last_beat = busy && (beat == (chop ? BEAT_LAST_CHOP : BEAT_LAST_FULL));

    // Burst engine
    always_ff @(posedge link_clk) begin
        if (link_reset) begin
            busy <= 1'b0;
            is_rd <= 1'b0;
            chop <= 1'b0;
            autoclose <= 1'b0;
            beat <= 2'h0;
            bank <= '0;
            col <= '0;
        end else if (fire) begin
            busy <= 1'b1;
            is_rd <= line[0].rd;
            chop <= line[0].chop;
            autoclose <= line[0].autoclose;
            beat <= 2'h0;
            bank <= line[0].bank;
            col <= line[0].col;
        end else if (last_beat) begin
            busy <= 1'b0;
        end else if (busy) begin
            beat <= beat + 1'b1;
        end
    end

    // Read drive: data and strobe from the first clock of the burst until its last
    always_ff @(posedge link_clk) begin
        if (link_reset) begin
            dq_out <= '0;
            dq_oe_n <= 1'b1;
            dqs_out <= 1'b0;
            dqs_oe_n <= 1'b1;
        end else if (rd_fire) begin
            dq_out <= mem[{line[0].col, 2'h0}];
            dq_oe_n <= 1'b0;
            dqs_out <= 1'b1;
            dqs_oe_n <= 1'b0;
        end else if (busy && is_rd && !last_beat) begin
            dq_out <= mem[{col, beat + 1'b1}];
            dqs_out <= ~dqs_out;
        end else begin
            dq_oe_n <= 1'b1;
            dqs_oe_n <= 1'b1;
            dqs_out <= 1'b0;
        end
    end

    // Write capture, one beat pair per clock
    always_ff @(posedge link_clk) begin
        if (busy && !is_rd) begin
            mem[{col, beat}] <= dq_in;
        end
    end

    // Bank state
    always_ff @(posedge link_clk) begin
        if (link_reset) begin
            bank_open <= '0;
        end else begin
            if (cmd.act) begin
                bank_open[cmd.bank] <= 1'b1;
            end
            if (cmd.pre) begin
                bank_open[cmd.bank] <= 1'b0;
            end
            if (last_beat && autoclose) begin
                bank_open[bank] <= 1'b0;
            end
        end
    end

    // Bank state reported on the core clock
    always_ff @(posedge clk) begin
        if (reset) begin
            bank_sync <= '0;
            bank_open_status <= '0;
        end else begin
            bank_sync <= bank_open;
            bank_open_status <= bank_sync;
        end
    end

    // Checks
    logic [LAT_W-1:0] since_rd;
    logic [LAT_W-1:0] since_wr;

    always_ff @(posedge link_clk) begin
        if (link_reset) begin
            since_rd <= '1;
            since_wr <= '1;
        end else begin
            if (cmd.rd) begin
                since_rd <= LAT_W'(1);
            end else if (since_rd != '1) begin
                since_rd <= since_rd + 1'b1;
            end
            if (cmd.wr) begin
                since_wr <= LAT_W'(1);
            end else if (since_wr != '1) begin
                since_wr <= since_wr + 1'b1;
            end
        end
    end

    default clocking cb @(posedge link_clk);
    endclocking
    default disable iff (link_reset);

    read_latency_a: assert property (read_latency_sum > LAT_W'(1) && since_rd == read_latency_sum
        |-> rd_fire ##1 !dq_oe_n) else $error("read data not started at read latency");
    write_latency_a: assert property (write_latency_sum > LAT_W'(1) && since_wr == write_latency_sum
        |-> fire && !line[0].rd ##1 busy && !is_rd) else $error("write capture not started at write latency");
    full_burst_a: assert property ($fell(dq_oe_n) && !chop
        |-> (!dq_oe_n)[*4] ##1 (dq_oe_n || $past(rd_fire))) else $error("eight-beat read drive length wrong");
    chop_burst_a: assert property ($fell(dq_oe_n) && chop
        |-> (!dq_oe_n)[*2] ##1 (dq_oe_n || $past(rd_fire))) else $error("chopped read drive length wrong");
    autoclose_a: assert property (last_beat && autoclose
        |=> !bank_open[$past(bank)]) else $error("bank not closed after autoclose burst");
    keep_open_a: assert property (last_beat && !autoclose && !cmd.act && !cmd.pre
        |=> bank_open == $past(bank_open)) else $error("bank state changed after plain burst");
    fixed_chop_a: assert property (link_cfg.burst_field == BURST_FIXED_CHOP && cmd.rd
        |-> next_slot.valid && next_slot.chop) else $error("fixed chop not applied");
    per_command_a: assert property (link_cfg.burst_field == BURST_PER_COMMAND && (cmd.rd || cmd.wr)
        |-> next_slot.chop == !cmd.burst_chop_address_bit) else $error("per-command burst choice wrong");
    fixed_full_a: assert property (link_cfg.burst_field == BURST_FIXED_FULL && cmd.rd
        |-> !next_slot.chop) else $error("fixed eight-beat burst chopped");

    full_read_c: cover property (rd_fire && !line[0].chop ##1 !dq_oe_n);
    chop_read_c: cover property (rd_fire && line[0].chop ##1 !dq_oe_n);
    write_burst_c: cover property (fire && !line[0].rd ##1 busy);
    autoclose_c: cover property (last_beat && autoclose && is_rd);

endmodule : ddr_burst_device

// ---- tb/ddr_ctl_model.sv ----
// Controller model: one-cycle commands and write data on link_clk.
// Assumes callers enter its tasks just after a rising link_clk edge.
module ddr_ctl_model
    import ddr_burst_pkg::*;
#(
    parameter int READ_TO_CLOSE = 4,
    parameter int OPEN_TO_CLOSE_MIN = 10,
    parameter int CLOSE_RECOVERY = 4,
    parameter int ROW_CYCLE = 14
) (
    input wire logic link_clk,
    output cmd_t cmd,
    output logic [PAIR_W-1:0] dq_in
);
    timeunit 1ns;
    timeprecision 100ps;
    int since_act = 99;
    int since_pre = 99;
    int since_rd = 99;
    int since_col = 99;
    initial cmd = '0;
    initial dq_in = '0;
    always @(posedge link_clk) begin
        since_act <= cmd.act ? 1 : since_act + 1;
        since_pre <= cmd.pre ? 1 : since_pre + 1;
        since_rd <= cmd.rd ? 1 : since_rd + 1;
        since_col <= (cmd.rd || cmd.wr) ? 1 : since_col + 1;
    end
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge link_clk);
            #1;
        end
    endtask : idle
    // Holds a command back until its spacing is met
    task automatic issue(input cmd_t c, input int al, input int rd_to_wr);
        idle(1);
        while ((c.pre && (since_act < OPEN_TO_CLOSE_MIN || since_rd < al + READ_TO_CLOSE))
            || (c.act && (since_pre < CLOSE_RECOVERY || since_act < ROW_CYCLE))
            || ((c.rd || c.wr) && since_col < CLOCKS_FULL)
            || (c.wr && since_rd < rd_to_wr)) begin
            idle(1);
        end
        cmd = c;
        idle(1);
        cmd = '0;
    endtask : issue
    // Pairs held one clock each from cycle wl, then the inverse of the last
    task automatic wr_data(input int wl, input int n, input logic [PAIR_W-1:0] d [4]);
        idle(wl);
        for (int k = 0; k < n; k++) begin
            dq_in = d[k];
            idle(1);
        end
        dq_in = ~dq_in;
    endtask : wr_data
endmodule : ddr_ctl_model

// ---- tb/tb.sv ----
// Testbench: bursts through the controller model, checks read beats and bank state.
// Assumes the package, the device and ddr_ctl_model are compiled first.
module tb
    import ddr_burst_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int AL = 2;
    localparam int CL = 5;
    localparam int COLUMN_WRITE_DELAY = 6;
    localparam int RL = AL + CL;
    localparam int WL = AL + COLUMN_WRITE_DELAY;
    localparam int RD_TO_WR = CL - COLUMN_WRITE_DELAY + CLOCKS_FULL + 1 + 2;
    typedef struct {
        int cyc;
        logic [PAIR_W-1:0] data;
        logic dqs;
    } note_t;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic reset = 1'b1;
    logic mon_on = 1'b0;
    cfg_t cfg;
    cmd_t cmd;
    logic [NUM_BANKS-1:0] bank_open_status;
    logic [PAIR_W-1:0] dq_in;
    logic [PAIR_W-1:0] dq_out;
    logic dq_oe_n;
    logic dqs_out;
    logic dqs_oe_n;
    logic [31:0] rng = 32'h1ed8;
    logic [PAIR_W-1:0] exp_mem [16][4];
    note_t q [$];
    int lcyc = 0;
    int n_errors = 0;
    int total_checks = 0;

    ddr_burst_device #(.LAT_DEPTH(64)) dut_u (.clk(clk), .reset(reset), .cfg(cfg),
        .bank_open_status(bank_open_status), .link_clk(link_clk), .cmd(cmd), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dqs_out(dqs_out), .dqs_oe_n(dqs_oe_n));
    ddr_ctl_model ctl_u (.link_clk(link_clk), .cmd(cmd), .dq_in(dq_in));

    always #(CLK_PERIOD_NS / 2) clk = ~clk;
    initial begin
        #3.3;
        forever #16 link_clk = ~link_clk;
    end
    always @(posedge link_clk) lcyc <= lcyc + 1;

    function automatic logic [31:0] xorshift();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : xorshift
    task automatic report(input string m);
        n_errors++;
        $display("ERROR %0t %s", $time, m);
    endtask : report
    task automatic finish_test();
        if (n_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test
    task automatic check_pair(input note_t e);
        total_checks++;
        if (e.cyc != lcyc || dq_out !== e.data || dqs_out !== e.dqs || dqs_oe_n !== 1'b0) begin
            report($sformatf("read beat cycle %0d want %0d data %h want %h", lcyc, e.cyc, dq_out, e.data));
        end
    endtask : check_pair
    task automatic check_bank(input int b, input logic e);
        int i;
        i = 0;
        while (bank_open_status[b] !== e && i < 40) begin
            @(posedge clk);
            #1;
            i++;
        end
        total_checks++;
        if (bank_open_status[b] !== e) begin
            report($sformatf("bank %0d open flag not %b", b, e));
        end
    endtask : check_bank
    task automatic bank_cmd(input int b, input logic open);
        cmd_t x;
        x = '0;
        x.act = open;
        x.pre = !open;
        x.bank = 3'(b);
        ctl_u.issue(x, AL, RD_TO_WR);
        check_bank(b, open);
    endtask : bank_cmd
    task automatic burst(input int b, input logic [3:0] c, input logic bit12, input logic wr, input logic ac);
        cmd_t x;
        logic [PAIR_W-1:0] d [4];
        int n;
        x = '0;
        x.rd = !wr;
        x.wr = wr;
        x.bank = 3'(b);
        x.col = c;
        x.burst_chop_address_bit = bit12;
        x.autoclose_address_bit = ac;
        n = (cfg.burst_field == 2'h2 || (cfg.burst_field == 2'h1 && !bit12)) ? 2 : 4;
        for (int k = 0; k < 4; k++) begin
            d[k] = xorshift();
        end
        ctl_u.issue(x, AL, RD_TO_WR);
        if (wr) begin
            ctl_u.wr_data(WL, n, d);
            for (int k = 0; k < n; k++) begin
                exp_mem[c][k] = d[k];
            end
        end else begin
            for (int k = 0; k < n; k++) begin
                q.push_back('{lcyc + RL + k, exp_mem[c][k], k % 2 == 0});
            end
        end
    endtask : burst
    task automatic run_case(input int b, input logic [3:0] c, input logic bit12, input logic ac);
        bank_cmd(b, 1'b1);
        burst(b, c, bit12, 1'b1, 1'b0);
        burst(b, c, bit12, 1'b0, ac);
        ctl_u.idle(RL + 8);
        check_bank(b, !ac);
        if (!ac) begin
            bank_cmd(b, 1'b0);
        end
    endtask : run_case

    // Pops a note for every driven beat
    always @(posedge link_clk) begin
        #1;
        if (mon_on && dq_oe_n === 1'b0) begin
            if (q.size() == 0) begin
                report("data driven outside a burst");
            end else begin
                check_pair(q.pop_front());
            end
        end else if (mon_on && (dq_oe_n !== 1'b1 || dqs_oe_n !== 1'b1 || (q.size() > 0 && q[0].cyc <= lcyc))) begin
            report("bus not idle or beat missing");
            q = {};
        end
    end

    initial begin
        cfg = '{burst_field: BURST_FIXED_FULL, additive_delay: 5'(AL), column_read_delay: 5'(CL),
            column_write_delay: 5'(COLUMN_WRITE_DELAY)};
        repeat (20) @(posedge clk);
        #1;
        reset = 1'b0;
        ctl_u.idle(20);
        mon_on = 1'b1;
        for (int f = 3; f >= 0; f--) begin
            @(posedge clk);
            #1;
            cfg.burst_field = 2'(f);
            ctl_u.idle(30);
            for (int m = 0; m < 4; m++) begin
                run_case((f * 4 + m) % NUM_BANKS, 4'(xorshift()), m[0], m[1]);
            end
        end
        // Two writes to bank 7, then back-to-back reads at the minimum spacing
        bank_cmd(7, 1'b1);
        burst(7, 4'h3, 1'b1, 1'b1, 1'b0);
        burst(7, 4'hc, 1'b1, 1'b1, 1'b0);
        burst(7, 4'h3, 1'b1, 1'b0, 1'b0);
        burst(7, 4'hc, 1'b1, 1'b0, 1'b0);
        ctl_u.idle(RL + 8);
        finish_test();
    end
    initial begin
        #400000;
        report("timeout");
        finish_test();
    end
endmodule : tb
